// file: core/lshed_pkg.sv
// Package of register map, fields and timing for the load shedding controller
// Behaviour
// - Up to five shedding outputs; none driven while the feature is disabled.
// - On about-to-take-load, energise start-count outputs before load switch closes.
// - On load, start trip delay while loading exceeds trip level.
// - Trip delay expiry with loading still high energises the lowest output not yet energised.
// - Each further full trip period above level energises the next output.
// - Loading below return level starts the return delay.
// - Return delay expiry with loading still low drops the highest output.
// - Repeat return delay steps, one output each, until none energised.
// - Stopping sequence drops all outputs with the load switch open command.
package lshed_pkg;
  localparam int unsigned NOUT = 5;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TRIP = 12'h004;
  localparam logic [11:0] ADDR_RET = 12'h008;
  localparam logic [11:0] ADDR_TDLY = 12'h00c;
  localparam logic [11:0] ADDR_RDLY = 12'h010;
  localparam logic [11:0] ADDR_STAT = 12'h014;
  localparam logic [11:0] ADDR_LOAD = 12'h018;
  // CTRL fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_NSCH_LSB = 4;
  localparam int unsigned CTRL_NSTART_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TRIP_RST = 16'hffff;
  localparam logic [15:0] RET_RST = 16'h0000;
  // Delays in ms, converted to cycles of a 1 ms tick
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam logic [15:0] TDLY_RST_MS = 16'h1388;
  localparam logic [15:0] RDLY_RST_MS = 16'h1388;
  localparam logic [31:0] SLVERR_RD = 32'h0000_0000;
endpackage : lshed_pkg

// file: core/lshed_top.sv
// Load shedding controller with APB register access
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module lshed_top
  import lshed_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = lshed_pkg::TICK_CYC
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] gen_load,
  input wire logic take_load_req,
  input wire logic on_load,
  input wire logic stop_req,
  output logic [lshed_pkg::NOUT-1:0] shed_out,
  output logic load_close_cmd,
  output logic load_open_cmd
);
  import lshed_pkg::*;

  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] trip_q, trip_d, ret_q, ret_d, tdly_q, tdly_d, rdly_q, rdly_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [15:0] load_s1_q, load_s2_q;
  logic [2:0] ev_s1_q, ev_s2_q, ev_prev_q;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic [15:0] ms_q, ms_d;
  logic [2:0] lvl_q, lvl_d;
  logic [NOUT-1:0] shed_q, shed_d;
  logic close_q, close_d, open_q, open_d;

  typedef enum logic [1:0] {LSHED_IDLE, LSHED_TRIP, LSHED_RET} lshed_tmr_t;
  lshed_tmr_t tmr_q, tmr_d;

  wire en = ctrl_q[CTRL_EN_BIT];
  wire [2:0] nsch = (ctrl_q[CTRL_NSCH_LSB +: 3] > 3'(NOUT)) ? 3'(NOUT)
                    : ctrl_q[CTRL_NSCH_LSB +: 3];
  wire [2:0] nstart = (ctrl_q[CTRL_NSTART_LSB +: 3] > nsch) ? nsch
                      : ctrl_q[CTRL_NSTART_LSB +: 3];
  wire take_rise = ev_s2_q[0] & ~ev_prev_q[0];
  wire stop_rise = ev_s2_q[2] & ~ev_prev_q[2];
  wire loaded = ev_s2_q[1];
  // Only the second stage is read, the first may still be settling
  wire over = load_s2_q > trip_q;
  wire under = load_s2_q < ret_q;
  wire acc = psel & penable & ~pready_q;
  // Writes land only at the edge that sees pready high
  wire wr_go = psel & penable & pready_q & pwrite;

  // Thermometer decode of the energised count
  function automatic logic [NOUT-1:0] lshed_therm(input logic [2:0] n);
    logic [NOUT-1:0] r;
    r = '0;
    for (int i = 0; i < NOUT; i++)
      r[i] = (3'(i) < n);
    return r;
  endfunction : lshed_therm

  always_comb
  begin
    ctrl_d = ctrl_q;
    trip_d = trip_q;
    ret_d = ret_q;
    tdly_d = tdly_q;
    rdly_d = rdly_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = acc;
    if (acc)
      prdata_d = SLVERR_RD;
    // Read data and errors settle in the first access cycle, writes one edge later
    if (acc || wr_go)
    begin
      case (paddr)
        ADDR_CTRL: if (!pwrite) prdata_d = ctrl_q;
                   else if (wr_go) ctrl_d = pwdata;
        ADDR_TRIP: if (!pwrite) prdata_d = {16'h0000, trip_q};
                   else if (wr_go) trip_d = pwdata[15:0];
        ADDR_RET: if (!pwrite) prdata_d = {16'h0000, ret_q};
                  else if (wr_go) ret_d = pwdata[15:0];
        ADDR_TDLY: if (!pwrite) prdata_d = {16'h0000, tdly_q};
                   else if (wr_go) tdly_d = pwdata[15:0];
        ADDR_RDLY: if (!pwrite) prdata_d = {16'h0000, rdly_q};
                   else if (wr_go) rdly_d = pwdata[15:0];
        ADDR_STAT: if (pwrite) pslverr_d = acc;
                   else prdata_d = {24'h000000, tmr_q == LSHED_RET, tmr_q == LSHED_TRIP,
                                    1'b0, shed_q};
        ADDR_LOAD: if (pwrite) pslverr_d = acc; else prdata_d = {16'h0000, load_s2_q};
        default: pslverr_d = acc;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RST;
      trip_q <= TRIP_RST;
      ret_q <= RET_RST;
      tdly_q <= TDLY_RST_MS;
      rdly_q <= RDLY_RST_MS;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      trip_q <= trip_d;
      ret_q <= ret_d;
      tdly_q <= tdly_d;
      rdly_q <= rdly_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Measurement and sequencer events come from outside this clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      load_s1_q <= 16'h0000;
      load_s2_q <= 16'h0000;
      ev_s1_q <= 3'h0;
      ev_s2_q <= 3'h0;
      ev_prev_q <= 3'h0;
    end
    else
    begin
      load_s1_q <= gen_load;
      load_s2_q <= load_s1_q;
      ev_s1_q <= {stop_req, on_load, take_load_req};
      ev_s2_q <= ev_s1_q;
      ev_prev_q <= ev_s2_q;
    end
  end

  assign tick = (tick_cnt_q == TICK_CYCLES - 1);

  always_comb
  begin
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    ms_d = ms_q;
    tmr_d = tmr_q;
    lvl_d = lvl_q;
    close_d = 1'b0;
    open_d = 1'b0;
    if (stop_rise)
    begin
      lvl_d = 3'h0;
      open_d = 1'b1;
      tmr_d = LSHED_IDLE;
    end
    else if (take_rise)
    begin
      if (en)
        lvl_d = nstart;
      close_d = 1'b1; // Outputs register this cycle, close follows one cycle later
    end
    else if (en && loaded)
    begin
      case (tmr_q)
        LSHED_IDLE:
          if (over && lvl_q < nsch)
          begin
            tmr_d = LSHED_TRIP;
            ms_d = 16'h0000;
          end
          else if (under && lvl_q != 3'h0)
          begin
            tmr_d = LSHED_RET;
            ms_d = 16'h0000;
          end
        LSHED_TRIP:
          if (!over)
            tmr_d = LSHED_IDLE;
          else if (tick)
          begin
            ms_d = ms_q + 16'h0001;
            if (ms_q + 16'h0001 >= tdly_q)
            begin
              lvl_d = lvl_q + 3'h1;
              ms_d = 16'h0000;
              if (lvl_q + 3'h1 >= nsch)
                tmr_d = LSHED_IDLE;
            end
          end
        LSHED_RET:
          if (!under)
            tmr_d = LSHED_IDLE;
          else if (tick)
          begin
            ms_d = ms_q + 16'h0001;
            if (ms_q + 16'h0001 >= rdly_q)
            begin
              lvl_d = lvl_q - 3'h1;
              ms_d = 16'h0000;
              if (lvl_q == 3'h1)
                tmr_d = LSHED_IDLE;
            end
          end
        default: tmr_d = LSHED_IDLE;
      endcase
    end
    if (!en)
    begin
      lvl_d = 3'h0;
      tmr_d = LSHED_IDLE;
    end
    if (lvl_d > nsch)
      lvl_d = nsch;
    shed_d = lshed_therm(lvl_d);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tick_cnt_q <= 32'h0000_0000;
      ms_q <= 16'h0000;
      tmr_q <= LSHED_IDLE;
      lvl_q <= 3'h0;
      shed_q <= '0;
      close_q <= 1'b0;
      open_q <= 1'b0;
      load_close_cmd <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      ms_q <= ms_d;
      tmr_q <= tmr_d;
      lvl_q <= lvl_d;
      shed_q <= shed_d;
      close_q <= close_d;
      open_q <= open_d;
      load_close_cmd <= close_q;
    end
  end

  assign shed_out = shed_q;
  assign load_open_cmd = open_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : lshed_top

// file: tb/lshed_sva.sv
// Checker on the shedding outputs and load switch commands
`timescale 1ns/100ps
module lshed_sva
  import lshed_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic take_load_req,
  input wire logic on_load,
  input wire logic stop_req,
  input wire logic [lshed_pkg::NOUT-1:0] shed_out,
  input wire logic load_close_cmd,
  input wire logic load_open_cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_therm; (shed_out & (shed_out + 1'b1)) == '0; endproperty
  a_therm: assert property (p_therm) else $error("outputs not lowest first");
  property p_open; load_open_cmd |-> shed_out == '0; endproperty
  a_open: assert property (p_open) else $error("outputs on at open");
  property p_stop; $rose(stop_req) && shed_out != '0 |-> ##[1:6] load_open_cmd; endproperty
  a_stop: assert property (p_stop) else $error("no open on stop");
  property p_close; load_close_cmd |-> $stable(shed_out) && $past(take_load_req, 3); endproperty
  a_close: assert property (p_close) else $error("close before outputs");
  property p_up; shed_out > $past(shed_out) |-> shed_out == ($past(shed_out) << 1 | 1'b1)
    or ##1 load_close_cmd; endproperty
  a_up: assert property (p_up) else $error("step up not by one");
  property p_down; shed_out < $past(shed_out) |-> shed_out == $past(shed_out) >> 1
    || shed_out == '0; endproperty
  a_down: assert property (p_down) else $error("step down not highest");
  property p_onload; shed_out > $past(shed_out) |-> $past(on_load, 3) or ##1 load_close_cmd;
  endproperty
  a_onload: assert property (p_onload) else $error("trip step off load");
  property p_openp; load_open_cmd |=> !load_open_cmd && shed_out == '0; endproperty
  a_openp: assert property (p_openp) else $error("outputs back after open");
endmodule : lshed_sva

// file: tb/lshed_gen_model.sv
// Generator sequencer model: load switch state from the close and open commands
`timescale 1ns/100ps
module lshed_gen_model
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load_close_cmd,
  input wire logic load_open_cmd,
  output logic on_load
);
  logic on_load_q, on_load_d;
  // Open wins, a switch never closes against an open command
  always_comb
    on_load_d = load_open_cmd ? 1'b0 : (load_close_cmd ? 1'b1 : on_load_q);
  always_ff @(posedge sys_clk)
    on_load_q <= sys_rst ? 1'b0 : on_load_d;
  assign on_load = on_load_q;
endmodule : lshed_gen_model

// file: tb/tb_top.sv
// Self-checking testbench for the load shedding controller
`timescale 1ns/100ps
module tb_top;
  import lshed_pkg::*;
  localparam int unsigned TICK_CYCLES = 10;
  localparam logic [11:0] ra [8] = '{ADDR_TRIP, ADDR_RET, ADDR_TDLY, ADDR_RDLY, ADDR_STAT,
    ADDR_LOAD, 12'h01c, ADDR_CTRL};
  localparam logic [31:0] rw [8] = '{32'h64, 32'h32, 32'h2, 32'h2, 32'h0, 32'h0, 32'h0,
    32'h251};
  // Status idle and nothing shed, load input still zero
  localparam logic [32:0] rx [8] = '{{17'h0, TRIP_RST}, {17'h0, RET_RST}, {17'h0, TDLY_RST_MS},
    {17'h0, RDLY_RST_MS}, 33'h0, 33'h0, {1'b1, SLVERR_RD}, {1'b0, CTRL_RST}};
  logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, on_load, load_close_cmd, load_open_cmd;
  logic [15:0] gen_load = 16'h0000;
  logic take_load_req = 1'b0, stop_req = 1'b0;
  logic [NOUT-1:0] shed_out;
  int n_errors = 0, tests_run = 0, t;
  lshed_top #(.TICK_CYCLES(TICK_CYCLES)) dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .gen_load, .take_load_req, .on_load,
    .stop_req, .shed_out, .load_close_cmd, .load_open_cmd);
  lshed_gen_model u_gen (.sys_clk, .sys_rst, .load_close_cmd, .load_open_cmd, .on_load);
  initial
    forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Values read right after the edge are the ones sampled at it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle count assumed; the watchdog ends a hung transfer
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_shed(input logic [NOUT-1:0] v);
    t = 0;
    while (shed_out !== v && t++ < 400) @(posedge sys_clk);
    chk(shed_out, v, "shed_out");
  endtask : wait_shed
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100us;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk(shed_out, 5'h00, "reset");
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk({err, rd}, rx[i], "register");
      apb(1'b1, ra[i], rw[i]);
    end
    gen_load <= 16'h0050;
    take_load_req <= 1'b1;
    t = 0;
    while (load_close_cmd !== 1'b1 && t++ < 50) @(posedge sys_clk);
    chk({load_close_cmd, shed_out}, {1'b1, 5'h03}, "start");
    // Short burst over trip then exactly at trip: the trip delay must not finish
    gen_load <= 16'h00c8;
    repeat (8) @(posedge sys_clk);
    gen_load <= 16'h0064;
    repeat (60) @(posedge sys_clk);
    chk(shed_out, 5'h03, "trip cancel");
    gen_load <= 16'h00c8;
    wait_shed(5'h07);
    wait_shed(5'h0f);
    wait_shed(5'h1f);
    // Short dip then exactly at trip: the return delay must not finish
    gen_load <= 16'h0010;
    repeat (8) @(posedge sys_clk);
    gen_load <= 16'h0064;
    repeat (60) @(posedge sys_clk);
    chk(shed_out, 5'h1f, "cancel");
    gen_load <= 16'h0010;
    wait_shed(5'h0f);
    wait_shed(5'h07);
    stop_req <= 1'b1;
    t = 0;
    while (load_open_cmd !== 1'b1 && t++ < 50) @(posedge sys_clk);
    chk({load_open_cmd, shed_out}, {1'b1, 5'h00}, "stop");
    stop_req <= 1'b0;
    take_load_req <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h250);
    take_load_req <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(shed_out, 5'h00, "disabled");
    report_and_stop();
  end
endmodule : tb_top
bind lshed_top lshed_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.sys_clk, .sys_rst, .take_load_req,
  .on_load, .stop_req, .shed_out, .load_close_cmd, .load_open_cmd);
